/* File: hw/sis_top.sv */
// System integrity status block: supply warning, clock supervisor and status register
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module sis_top
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic supply_warning_detector,
	input wire logic main_oscillator_clock,
	input wire logic main_osc_glitch,
	input wire sis_pkg::sis_reset_cause_type reset_cause,
	input wire logic reset_delay_active,
	input wire logic global_irq_mask,
	input wire logic warn_service_ack,
	input wire logic halt_mode,
	input wire logic wait_mode,
	output sis_pkg::sis_irq_type irq,
	output sis_pkg::sis_clk_state_type clock_select,
	output logic safe_oscillator_enable,
	output logic clock_filter_enable
);
	import sis_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [2:0] warn_sync;
	logic [2:0] osc_sync;
	logic warn_level;
	logic osc_level;

	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_sync <= 3'h0;
			osc_sync <= 3'h0;
		end
		else
		begin
			warn_sync <= {warn_sync[1:0], supply_warning_detector};
			osc_sync <= {osc_sync[1:0], main_oscillator_clock};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_level <= 1'b0;
			osc_level <= 1'b0;
		end
		else
		begin
			if (warn_sync[1] == warn_sync[2])
			begin
				warn_level <= warn_sync[2];
			end
			if (osc_sync[1] == osc_sync[2])
			begin
				osc_level <= osc_sync[2];
			end
		end
	end

	// ****************************************************************
	// Configuration register (option settings)
	// ****************************************************************
	logic [7:0] config_reg;
	logic opt_lvd_en;
	logic opt_css_en;
	logic opt_pll_en;
	logic opt_long_delay;

	assign opt_lvd_en = config_reg[BIT_OPT_LVD_EN];
	assign opt_css_en = config_reg[BIT_OPT_CSS_EN];
	assign opt_pll_en = config_reg[BIT_OPT_PLL_EN];
	assign opt_long_delay = config_reg[BIT_OPT_LONG_DELAY];

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic wr_status;
	logic wr_config;
	logic rd_status;
	logic bus_hit;
	logic rd_pending;

	// Writes finish in the cycle they arrive; reads take one wait cycle
	assign avs_waitrequest = avs_read && !rd_pending;
	assign bus_hit = (avs_address == ADDR_CTRL_STATUS) || (avs_address == ADDR_CONFIG);
	assign wr_status = avs_write && avs_byteenable[0] && (avs_address == ADDR_CTRL_STATUS);
	assign wr_config = avs_write && avs_byteenable[0] && (avs_address == ADDR_CONFIG);
	assign rd_status = avs_read && rd_pending && (avs_address == ADDR_CTRL_STATUS);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_pending <= 1'b0;
		end
		else
		begin
			rd_pending <= avs_read && !rd_pending;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			config_reg <= CONFIG_RESET;
		end
		else if (wr_config && !halt_mode)
		begin
			config_reg <= avs_writedata[7:0];
		end
	end

	// ****************************************************************
	// Supply warning
	// ****************************************************************
	logic warn_flag;
	logic warn_prev;
	logic warn_ie;
	logic warn_ie_prev;
	logic warn_pending;
	logic [DELAY_W-1:0] delay_count;
	logic in_reset_window;

	// Live comparator value, gated off when the detector option is off
	assign warn_flag = opt_lvd_en && warn_level;

	// Cycles since the reset delay phase ended; falling crossings inside it are dropped
	always_ff @(posedge clk)
	begin
		if (!rst_n || reset_delay_active)
		begin
			delay_count <= '0;
		end
		else if (in_reset_window)
		begin
			delay_count <= delay_count + DELAY_W'(1);
		end
	end

	assign in_reset_window = delay_count < (opt_long_delay ? LONG_DELAY : SHORT_DELAY);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_prev <= 1'b0;
			warn_ie_prev <= 1'b0;
		end
		else
		begin
			warn_prev <= warn_flag;
			warn_ie_prev <= warn_ie;
		end
	end

	// Pending warning: set on every toggle except a fall inside the reset window, and on enable while still below threshold
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_pending <= 1'b0;
		end
		else if (warn_ie && !halt_mode &&
			(((warn_flag != warn_prev) && !(in_reset_window && !warn_flag)) ||
			(!warn_ie_prev && warn_flag)))
		begin
			warn_pending <= 1'b1;
		end
		else if (warn_service_ack || !warn_ie)
		begin
			warn_pending <= 1'b0;
		end
	end

	// ****************************************************************
	// Clock supervisor
	// ****************************************************************
	logic osc_prev;
	logic [LOSS_W-1:0] idle_count;
	logic [LOSS_W-1:0] edge_count;
	logic clk_lost;
	logic clk_back;
	sis_clk_state_type clk_state;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			osc_prev <= 1'b0;
		end
		else
		begin
			osc_prev <= osc_level;
		end
	end

	// Edge watchdog on the sampled main clock; a single glitch only counts as an edge
	// when the filter is off, since the multiplier then passes it straight through
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			idle_count <= '0;
			edge_count <= '0;
		end
		else if (osc_level != osc_prev && !(main_osc_glitch && opt_pll_en))
		begin
			idle_count <= '0;
			if (edge_count != RECOVER_LIMIT)
			begin
				edge_count <= edge_count + LOSS_W'(1);
			end
		end
		else if (idle_count != LOSS_LIMIT)
		begin
			idle_count <= idle_count + LOSS_W'(1);
			if (idle_count == LOSS_LIMIT - LOSS_W'(1))
			begin
				edge_count <= '0;
			end
		end
	end

	assign clk_lost = idle_count == LOSS_LIMIT;
	assign clk_back = edge_count == RECOVER_LIMIT;
	assign clock_filter_enable = opt_pll_en;

	// Halt parks the supervisor but keeps its setup, so an interrupt wake resumes it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clk_state <= CLK_MAIN;
		end
		else
		begin
			unique case (clk_state)
				CLK_MAIN:
				begin
					if (halt_mode)
					begin
						clk_state <= CLK_HALTED;
					end
					else if (opt_css_en && clk_lost)
					begin
						clk_state <= CLK_SAFE;
					end
				end
				CLK_SAFE:
				begin
					if (halt_mode)
					begin
						clk_state <= CLK_HALTED;
					end
					else if (clk_back || !opt_css_en)
					begin
						clk_state <= CLK_MAIN;
					end
				end
				CLK_HALTED:
				begin
					if (!halt_mode)
					begin
						clk_state <= CLK_MAIN;
					end
				end
				default:
				begin
					clk_state <= CLK_MAIN;
				end
			endcase
		end
	end

	assign clock_select = clk_state;
	assign safe_oscillator_enable = opt_css_en && (clk_state != CLK_HALTED);

	// ****************************************************************
	// Control/status register
	// ****************************************************************
	logic clkf_ie;
	logic clkf_flag;
	logic lvr_flag;
	logic wdg_flag;
	logic [7:0] status_value;

	// Enables; frozen in halt
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_ie <= CTRL_STATUS_RESET[BIT_WARN_IE];
			clkf_ie <= CTRL_STATUS_RESET[BIT_CLKF_IE];
		end
		else if (wr_status && !halt_mode)
		begin
			warn_ie <= avs_writedata[BIT_WARN_IE];
			clkf_ie <= avs_writedata[BIT_CLKF_IE];
		end
	end

	// Clock failure flag: hardware set wins over a clearing read
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clkf_flag <= CTRL_STATUS_RESET[BIT_CLKF_FLAG];
		end
		else if (!opt_css_en)
		begin
			clkf_flag <= 1'b0;
		end
		else if (clk_state == CLK_SAFE)
		begin
			clkf_flag <= 1'b1;
		end
		else if (rd_status && !halt_mode)
		begin
			clkf_flag <= 1'b0;
		end
	end

	// Reset-source flags survive rst_n: they record causes from the reset manager.
	// Set beats a software clear of zero landing in the same cycle.
	always_ff @(posedge clk)
	begin
		if (reset_cause.low_voltage_reset_detector)
		begin
			lvr_flag <= 1'b1;
			wdg_flag <= 1'b0;
		end
		else if (reset_cause.watchdog)
		begin
			wdg_flag <= 1'b1;
		end
		else if (reset_cause.external)
		begin
			wdg_flag <= 1'b0;
		end
		else if (!rst_n)
		begin
			lvr_flag <= lvr_flag;
			wdg_flag <= wdg_flag;
		end
		else if (wr_status && !halt_mode)
		begin
			if (!avs_writedata[BIT_LVR_FLAG])
			begin
				lvr_flag <= 1'b0;
			end
			if (!avs_writedata[BIT_WDG_FLAG])
			begin
				wdg_flag <= 1'b0;
			end
		end
	end

	// Reserved bit reads zero whatever software wrote
	always_comb
	begin
		status_value = CTRL_STATUS_RESET;
		status_value[BIT_WARN_IE] = warn_ie;
		status_value[BIT_WARN_FLAG] = warn_flag;
		status_value[BIT_LVR_FLAG] = lvr_flag === 1'b1;
		status_value[BIT_RESERVED] = 1'b0;
		status_value[BIT_CLKF_IE] = clkf_ie;
		status_value[BIT_CLKF_FLAG] = clkf_flag;
		status_value[BIT_WDG_FLAG] = wdg_flag === 1'b1;
	end

	// Read data registered; unmapped addresses read zero with a slave error
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			avs_readdata <= 32'h0;
			avs_response <= 2'h0;
		end
		else if (avs_read && !rd_pending)
		begin
			avs_response <= bus_hit ? 2'h0 : 2'h2;
			if (avs_address == ADDR_CTRL_STATUS)
			begin
				avs_readdata <= {24'h0, status_value};
			end
			else if (avs_address == ADDR_CONFIG)
			begin
				avs_readdata <= {24'h0, config_reg};
			end
			else
			begin
				avs_readdata <= 32'h0;
			end
		end
	end

	// ****************************************************************
	// Interrupt requests
	// ****************************************************************
	logic clkf_req;
	logic warn_req;

	// Clock failure needs the supervisor option and the enable, set before or after the failure
	assign clkf_req = clkf_flag && clkf_ie && opt_css_en;
	assign warn_req = warn_pending && opt_lvd_en;

	// Requests masked globally, wake_wait unmasked; no wake from halt since wake_wait is gated off by halt_mode
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq <= '0;
		end
		else
		begin
			irq.warn_req <= warn_req && !global_irq_mask;
			irq.clkf_req <= clkf_req && !global_irq_mask;
			irq.wake_wait <= (warn_req || clkf_req) && wait_mode && !halt_mode;
		end
	end
endmodule
`default_nettype wire

/* File: hw/sis_pkg.sv */
// Package for the system integrity status block: register layout, timing and carriers
package sis_pkg;
	// ****************************************************************
	// Register map (byte address on the bus)
	// ****************************************************************
	localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CONFIG = 4'h4;
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

	// Field positions in the control/status register
	localparam int BIT_WARN_IE = 6;
	localparam int BIT_WARN_FLAG = 5;
	localparam int BIT_LVR_FLAG = 4;
	localparam int BIT_RESERVED = 3;
	localparam int BIT_CLKF_IE = 2;
	localparam int BIT_CLKF_FLAG = 1;
	localparam int BIT_WDG_FLAG = 0;

	// Field positions in the option configuration register
	localparam int BIT_OPT_LVD_EN = 0;
	localparam int BIT_OPT_CSS_EN = 1;
	localparam int BIT_OPT_PLL_EN = 2;
	localparam int BIT_OPT_LONG_DELAY = 3;
	localparam logic [7:0] CONFIG_RESET = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SHORT_DELAY_CYCLES = 256;
	localparam int LONG_DELAY_CYCLES = 4096;
	localparam int DELAY_W = 13;
	localparam logic [DELAY_W-1:0] SHORT_DELAY = DELAY_W'(SHORT_DELAY_CYCLES);
	localparam logic [DELAY_W-1:0] LONG_DELAY = DELAY_W'(LONG_DELAY_CYCLES);
	// Main clock declared lost after this many cycles without an edge
	localparam int LOSS_W = 4;
	localparam logic [LOSS_W-1:0] LOSS_LIMIT = 4'h8;
	// Main clock declared back after this many consecutive edges
	localparam logic [LOSS_W-1:0] RECOVER_LIMIT = 4'h4;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef enum logic [1:0]
	{
		CLK_MAIN = 2'b00,
		CLK_SAFE = 2'b01,
		CLK_HALTED = 2'b10
	} sis_clk_state_type;

	// Reset cause pulses from the reset sequence manager
	typedef struct packed
	{
		logic low_voltage_reset_detector;
		logic watchdog;
		logic external;
	} sis_reset_cause_type;

	// Interrupt requests toward the interrupt controller
	typedef struct packed
	{
		logic warn_req;
		logic clkf_req;
		logic wake_wait;
	} sis_irq_type;
endpackage

/* File: testbench/sis_props.sv */
// Concurrent checks on the ports of the system integrity status block
`timescale 1ns/1ps
`default_nettype none
module sis_props
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic global_irq_mask,
	input wire logic halt_mode,
	input wire logic wait_mode,
	input wire sis_pkg::sis_irq_type irq,
	input wire sis_pkg::sis_clk_state_type clock_select,
	input wire logic safe_oscillator_enable,
	input wire logic clock_filter_enable
);
	import sis_pkg::*;
	// ********
	// Port relations, single clock domain
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	rsv_zero_a:
	assert property (avs_read && !avs_waitrequest && avs_address == ADDR_CTRL_STATUS
		|-> avs_readdata[BIT_RESERVED] == 1'b0 && avs_readdata[31:8] == 24'h0)
		else $error("reserved bit reads high");
	filter_cfg_a:
	assert property (avs_write && avs_byteenable[0] && avs_address == ADDR_CONFIG && !halt_mode
		|=> clock_filter_enable == $past(avs_writedata[BIT_OPT_PLL_EN]))
		else $error("filter enable not following config");
	halt_state_a:
	assert property (halt_mode ##1 halt_mode |-> clock_select == CLK_HALTED)
		else $error("clock not halted");
	halt_osc_a:
	assert property (clock_select == CLK_HALTED |-> !safe_oscillator_enable)
		else $error("safe oscillator on in halt");
	safe_osc_a:
	assert property (clock_select == CLK_SAFE |-> safe_oscillator_enable)
		else $error("safe clock without oscillator");
	// Flag and read data each lag by a register, so look two cycles back
	clkf_read_a:
	assert property (avs_read && !avs_waitrequest && avs_address == ADDR_CTRL_STATUS
		&& $past(clock_select, 2) == CLK_SAFE && $past(clock_select) == CLK_SAFE
		|-> avs_readdata[BIT_CLKF_FLAG]) else $error("clock failure flag low");
	warn_mask_a:
	assert property (irq.warn_req |-> !$past(global_irq_mask))
		else $error("masked warning request");
	clkf_mask_a:
	assert property (irq.clkf_req |-> !$past(global_irq_mask))
		else $error("masked clock request");
	wake_wait_a:
	assert property (irq.wake_wait |-> $past(wait_mode)) else $error("wake outside wait");
	read_wait_a:
	assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read not stalled");
endmodule
bind sis_top sis_props i_sis_props
(
	.clk(clk),
	.rst_n(rst_n),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.global_irq_mask(global_irq_mask),
	.halt_mode(halt_mode),
	.wait_mode(wait_mode),
	.irq(irq),
	.clock_select(clock_select),
	.safe_oscillator_enable(safe_oscillator_enable),
	.clock_filter_enable(clock_filter_enable)
);
`default_nettype wire

/* File: testbench/test_sis_top.sv */
// Self-checking testbench for the system integrity status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
`define WAITC(c) begin checks_done++; for (w = 0; w < 400; w++) begin @(negedge clk); \
	if ((c) === 1'b1) break; end @(posedge clk); if (w == 400) begin n_mismatch++; \
	$display("mismatch %0t wait expired", $time); final_report(); end end
module test_sis_top;
	import sis_pkg::*;
	localparam logic [3:0] st = ADDR_CTRL_STATUS;
	localparam logic [3:0] cf = ADDR_CONFIG;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest, det, osc, glitch, rda, mask, ack;
	logic halt_mode, wait_mode, safe_oscillator_enable, clock_filter_enable, osc_run, osc_div;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	logic [1:0] avs_response, rresp;
	sis_reset_cause_type reset_cause;
	sis_irq_type irq;
	sis_clk_state_type clock_select;
	int n_mismatch, checks_done, w;
	sis_top i_sis_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.supply_warning_detector(det), .main_oscillator_clock(osc), .main_osc_glitch(glitch),
		.reset_cause(reset_cause), .reset_delay_active(rda), .global_irq_mask(mask),
		.warn_service_ack(ack), .halt_mode(halt_mode), .wait_mode(wait_mode), .irq(irq),
		.clock_select(clock_select), .safe_oscillator_enable(safe_oscillator_enable),
		.clock_filter_enable(clock_filter_enable));
	// ********
	// Clocks and bus tasks
	// ********
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Main oscillator runs at a quarter of the bench clock while enabled
	always @(posedge clk)
	begin
		osc_div <= !osc_div;
		if (osc_run && osc_div)
			osc <= !osc;
	end
	task automatic final_report();
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One Avalon transfer; waitrequest and read data are both taken at the rising edge
	task automatic xfer(input logic is_rd, input logic [3:0] a, input logic [7:0] d);
		int k;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= is_rd;
		avs_write <= !is_rd;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rdat = avs_readdata;
		rresp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k == 50)
		begin
			n_mismatch++;
			$display("mismatch %0t bus wait expired", $time);
			final_report();
		end
		// Idle edge so the next request never lands in the release time step
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		xfer(1'b0, a, d);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		xfer(1'b1, a, 8'h00);
		`CHK(rdat, {24'h0, e})
	endtask
	task automatic cause(input logic [2:0] c);
		reset_cause <= c;
		@(posedge clk);
		reset_cause <= 3'b000;
		@(posedge clk);
	endtask
	// Reset-delay pulses restart the window, ack pulses clear the warning; the two extra edges let registered irq settle
	task automatic pulse(input logic is_ack);
		ack <= is_ack;
		rda <= !is_ack;
		@(posedge clk);
		ack <= 1'b0;
		rda <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_flags();
		rchk(cf, CONFIG_RESET);
		cause(3'b100);
		rchk(st, 8'h10);
		cause(3'b010);
		rchk(st, 8'h11);
		cause(3'b001);
		rchk(st, 8'h10);
		wr(st, 8'h00);
		rchk(st, 8'h00);
		cause(3'b010);
		rchk(st, 8'h01);
		cause(3'b100);
		rchk(st, 8'h10);
		wr(st, 8'h00);
		cause(3'b010);
		wr(st, 8'h00);
		rchk(st, 8'h00);
		cause(3'b001);
		rchk(st, 8'h00);
	endtask
	task automatic t_rw();
		// Software keeps the reserved bit clear on every write to the status register
		wr(st, 8'h44);
		rchk(st, 8'h44);
		xfer(1'b1, 4'h8, 8'h00);
		`CHK(rresp, 2'b10)
		wr(4'h8, 8'hff);
		rchk(st, 8'h44);
	endtask
	task automatic t_warn();
		wr(cf, 8'h01);
		pulse(1'b0);
		repeat (300) @(posedge clk);
		wr(st, 8'h00);
		det <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(st, 8'h20);
		`CHK(irq.warn_req, 1'b0)
		wr(st, 8'h40);
		`WAITC(irq.warn_req)
		pulse(1'b1);
		`CHK(irq.warn_req, 1'b0)
		det <= 1'b0;
		repeat (8) @(posedge clk);
		rchk(st, 8'h40);
		`WAITC(irq.warn_req)
		pulse(1'b1);
		mask <= 1'b1;
		det <= 1'b1;
		repeat (12) @(posedge clk);
		`CHK(irq.warn_req, 1'b0)
		mask <= 1'b0;
		wait_mode <= 1'b1;
		`WAITC(irq.warn_req)
		`WAITC(irq.wake_wait)
		wait_mode <= 1'b0;
		pulse(1'b1);
		pulse(1'b0);
		det <= 1'b0;
		repeat (30) @(posedge clk);
		`CHK(irq.warn_req, 1'b0)
		repeat (300) @(posedge clk);
		wr(cf, 8'h00);
		det <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(st, 8'h40);
		`CHK(irq.warn_req, 1'b0)
	endtask
	task automatic t_clk();
		wr(st, 8'h04);
		wr(cf, 8'h02);
		osc_run <= 1'b0;
		`WAITC(clock_select === CLK_SAFE)
		`CHK(safe_oscillator_enable, 1'b1)
		`WAITC(irq.clkf_req)
		rchk(st, 8'h06);
		osc_run <= 1'b1;
		`WAITC(clock_select === CLK_MAIN)
		xfer(1'b1, st, 8'h00);
		rchk(st, 8'h04);
		// Without the multiplier, marked glitches still count as edges
		glitch <= 1'b1;
		repeat (30) @(posedge clk);
		`CHK(clock_select, CLK_MAIN)
		// With the multiplier, marked edges are filtered and the clock looks lost
		wr(cf, 8'h06);
		`CHK(clock_filter_enable, 1'b1)
		`WAITC(clock_select === CLK_SAFE)
		glitch <= 1'b0;
		`WAITC(clock_select === CLK_MAIN)
		xfer(1'b1, st, 8'h00);
		// Halt with the supervisor on, so the oscillator check means something
		halt_mode <= 1'b1;
		`WAITC(clock_select === CLK_HALTED)
		`CHK(safe_oscillator_enable, 1'b0)
		wr(st, 8'h40);
		halt_mode <= 1'b0;
		`WAITC(clock_select === CLK_MAIN)
		rchk(st, 8'h04);
		wr(cf, 8'h00);
		osc_run <= 1'b0;
		repeat (40) @(posedge clk);
		`CHK(clock_select, CLK_MAIN)
		`CHK(irq.clkf_req, 1'b0)
		rchk(st, 8'h04);
	endtask
	// Main sequence
	initial
	begin
		{rst_n, avs_read, avs_write, det, osc, glitch, rda, mask, ack} = 9'h0;
		{halt_mode, wait_mode, osc_div, reset_cause, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		osc_run = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_flags();
		t_rw();
		t_warn();
		t_clk();
		final_report();
	end
endmodule
`default_nettype wire
